/* File: hw/sio_port.sv */
`timescale 1ns/1ps
`include "sio_cfg.svh"

// Notes on behaviour
// - One 8-bit word per transfer, accessed as low and high 4-bit digits.
// - Start instruction clears the counter and moves start-wait to clock-wait.
// - Counting begins at a falling shift edge and advances on each rising edge.
// - Counter wrap after eight clocks, or start during transfer, returns to clock-wait and sets flag.
// - Mode write blocks shift clock, clears counter, aborts transfer setting the flag.
// - New mode value acts two cycles after the write; start only after that.
// - Mode register clears to zero on reset.
// - Mode bit 3 makes the clock pin a general port (0) or shift clock (1).
// - Mode bits 2:0 pick prescaler-divided, half-system-clock or external shift clock.
// - Serial output drives the word LSB first, changing on falling edges.
// - Serial input sampled on rising edges into the MSB end.
// - Request flag in bit 0, mask in bit 1; mask 1 blocks the request.
// - Port-mode bits 1:0 choose continuous clock, transmit, receive or both.
// - Port-mode change or mode write enters start-wait; clocks then ignored.
// - First falling edge in clock-wait enters transfer; counting and shifting follow.
// - Continuous clock mode stays in clock-wait and emits clocks forever.
// - Internal clock: start emits exactly eight pulses then stops.
// - Excess clocks go transfer, clock-wait, then transfer at the next fall.
// - Port-mode register clears to zero on reset, pins start as ports.
// - Prescaler counts on every system clock except reset and stop mode.
module sio_port (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_wdata,
    output logic [3:0] reg_rdata,
    input wire logic serial_start_instruction,
    input wire logic stop_mode,
    input wire logic sck_pin_in,
    output logic sck_pin_out,
    output logic sck_pin_oe,
    input wire logic si_pin_in,
    output logic so_pin_out,
    output logic so_pin_oe,
    output logic serial_request,
    output logic [3:0] pin_function,
    output sio_pkg::sio_state_t link_state
);
    import sio_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    sio_state_t state_q;
    logic [3:0] mode_q;
    logic [3:0] mode_new_q;
    logic [`SIO_MODE_APPLY_CYCLES-1:0] mode_pend_q;
    logic [3:0] pin_func_q;
    logic [7:0] data_q;
    logic [2:0] count_q;
    logic flag_q;
    logic mask_q;
    logic [3:0] rdata_q;
    logic request_q;
    logic [`SIO_PRESC_WIDTH-1:0] presc_q;
    logic sysdiv_q;
    logic tap_prev_q;
    logic want_q;
    logic run_q;
    logic sck_out_q;
    logic sck_oe_q;
    logic so_out_q;
    logic so_oe_q;
    logic ext_prev_q;

    logic tap;
    logic ext_level;
    logic si_level;
    logic wr_irq;
    logic wr_mode;
    logic wr_pf;
    logic pf_change;
    logic ext_sel;
    logic pin_fn;
    logic tx_en;
    logic rx_en;
    logic continuous;
    logic fall_ev;
    logic rise_ev;
    logic start_ev;
    logic wrap_ev;
    logic abort_ev;
    logic emit;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    assign wr_irq = reg_wr && (reg_addr == `SIO_OFS_IRQ_CTRL);
    assign wr_mode = reg_wr && (reg_addr == `SIO_OFS_MODE);
    assign wr_pf = reg_wr && (reg_addr == `SIO_OFS_PIN_FUNC);
    assign pf_change = wr_pf && (reg_wdata[1:0] != pin_func_q[1:0]);
    assign pin_fn = mode_q[`SIO_MODE_PIN_FN_BIT];
    assign ext_sel = (mode_q[2:0] == `SIO_CLK_EXT);
    assign tx_en = pin_func_q[`SIO_PF_TX_BIT];
    assign rx_en = pin_func_q[`SIO_PF_RX_BIT];
    assign continuous = pin_fn && !tx_en && !rx_en;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    sio_sync u_sck_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_in(sck_pin_in),
        .level(ext_level)
    );

    sio_sync u_si_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_in(si_pin_in),
        .level(si_level)
    );

    // ------------------------------------------------------------------
    // Prescaler and internal clock tap
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            presc_q <= '0;
            sysdiv_q <= 1'b0;
        end else if (!stop_mode) begin
            presc_q <= presc_q + {{(`SIO_PRESC_WIDTH-1){1'b0}}, 1'b1};
            sysdiv_q <= ~sysdiv_q;
        end
    end

    always_comb begin
        case (mode_q[2:0])
            3'h0: tap = presc_q[`SIO_TAP_DIV4096];
            3'h1: tap = presc_q[`SIO_TAP_DIV1024];
            3'h2: tap = presc_q[`SIO_TAP_DIV256];
            3'h3: tap = presc_q[`SIO_TAP_DIV64];
            3'h4: tap = presc_q[`SIO_TAP_DIV16];
            3'h5: tap = presc_q[`SIO_TAP_DIV4];
            3'h6: tap = sysdiv_q;
            default: tap = 1'b1;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tap_prev_q <= 1'b1;
            ext_prev_q <= 1'b1;
        end else begin
            tap_prev_q <= tap;
            ext_prev_q <= ext_level;
        end
    end

    // ------------------------------------------------------------------
    // Shift clock events
    // ------------------------------------------------------------------
    always_comb begin
        if (ext_sel) begin
            fall_ev = pin_fn && ext_prev_q && !ext_level;
            rise_ev = pin_fn && !ext_prev_q && ext_level;
        end else begin
            fall_ev = run_q && tap_prev_q && !tap;
            rise_ev = run_q && !tap_prev_q && tap;
        end
    end

    assign start_ev = serial_start_instruction && (state_q != SIO_TRANSFER || !wr_mode);
    assign wrap_ev = (state_q == SIO_TRANSFER) && rise_ev && (count_q == `SIO_LAST_COUNT);
    assign abort_ev = (state_q == SIO_TRANSFER) && (wr_mode || serial_start_instruction);
    assign emit = want_q || (continuous && state_q == SIO_WAIT_CLOCK);

    // ------------------------------------------------------------------
    // Internal clock generator
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            want_q <= 1'b0;
        end else if (wr_mode || pf_change || wrap_ev || ext_sel) begin
            want_q <= 1'b0;
        end else if (serial_start_instruction && !continuous) begin
            want_q <= 1'b1;
        end
    end

    // Start only while the tap is high so the first low phase is whole
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            run_q <= 1'b0;
        end else if (!emit || wrap_ev || ext_sel) begin
            run_q <= 1'b0;
        end else if (tap) begin
            run_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sck_out_q <= 1'b1;
            sck_oe_q <= 1'b0;
        end else begin
            sck_out_q <= run_q ? tap : 1'b1;
            sck_oe_q <= pin_fn && !ext_sel;
        end
    end

    // ------------------------------------------------------------------
    // Mode register with delayed take-over
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_new_q <= `SIO_MODE_RESET;
            mode_pend_q <= '0;
        end else begin
            mode_pend_q <= {mode_pend_q[`SIO_MODE_APPLY_CYCLES-2:0], wr_mode};
            if (wr_mode) begin
                mode_new_q <= reg_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_q <= `SIO_MODE_RESET;
        end else if (mode_pend_q[`SIO_MODE_APPLY_CYCLES-1]) begin
            mode_q <= mode_new_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_func_q <= `SIO_PIN_FUNC_RESET;
        end else if (wr_pf) begin
            pin_func_q <= reg_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Operating state sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= SIO_WAIT_START;
        end else if (wr_mode || pf_change) begin
            state_q <= SIO_WAIT_START;
        end else begin
            case (state_q)
                SIO_WAIT_START: begin
                    if (serial_start_instruction) begin
                        state_q <= SIO_WAIT_CLOCK;
                    end
                end
                SIO_WAIT_CLOCK: begin
                    if (fall_ev && !continuous) begin
                        state_q <= SIO_TRANSFER;
                    end
                end
                SIO_TRANSFER: begin
                    if (serial_start_instruction || wrap_ev) begin
                        state_q <= SIO_WAIT_CLOCK;
                    end
                end
                default: state_q <= SIO_WAIT_START;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Octal counter
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            count_q <= 3'h0;
        end else if (wr_mode || start_ev) begin
            count_q <= 3'h0;
        end else if (state_q == SIO_TRANSFER && rise_ev) begin
            count_q <= count_q + 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Shift data register and serial output
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            data_q <= `SIO_DATA_RESET;
        end else if (reg_wr && reg_addr == `SIO_OFS_DATA_LO) begin
            data_q[3:0] <= reg_wdata;
        end else if (reg_wr && reg_addr == `SIO_OFS_DATA_HI) begin
            data_q[7:4] <= reg_wdata;
        end else if (state_q == SIO_TRANSFER && rise_ev && !wr_mode) begin
            data_q <= {rx_en ? si_level : 1'b0, data_q[7:1]};
        end
    end

    // First fall of a word also presents bit 0
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            so_out_q <= 1'b1;
        end else if (fall_ev && state_q != SIO_WAIT_START && !continuous) begin
            so_out_q <= data_q[0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            so_oe_q <= 1'b0;
        end else begin
            so_oe_q <= pin_fn && tx_en;
        end
    end

    // ------------------------------------------------------------------
    // Request flag and mask; hardware set wins over software clear
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            flag_q <= 1'b0;
        end else if (wrap_ev || abort_ev) begin
            flag_q <= 1'b1;
        end else if (wr_irq && !reg_wdata[`SIO_IRQ_FLAG_BIT]) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mask_q <= `SIO_MASK_RESET;
        end else if (wr_irq) begin
            mask_q <= reg_wdata[`SIO_IRQ_MASK_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            request_q <= 1'b0;
        end else begin
            request_q <= flag_q && !mask_q;
        end
    end

    // ------------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_q <= 4'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                `SIO_OFS_IRQ_CTRL: rdata_q <= {2'b00, mask_q, flag_q};
                `SIO_OFS_DATA_LO: rdata_q <= data_q[3:0];
                `SIO_OFS_DATA_HI: rdata_q <= data_q[7:4];
                default: rdata_q <= 4'h0;
            endcase
        end else begin
            rdata_q <= 4'h0;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata = rdata_q;
    assign sck_pin_out = sck_out_q;
    assign sck_pin_oe = sck_oe_q;
    assign so_pin_out = so_out_q;
    assign so_pin_oe = so_oe_q;
    assign serial_request = request_q;
    assign pin_function = pin_func_q;
    assign link_state = state_q;

endmodule

/* File: hw/sio_cfg.svh */
`ifndef SIO_CFG_SVH
`define SIO_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SIO_OFS_IRQ_CTRL 4'h3
`define SIO_OFS_PIN_FUNC 4'h4
`define SIO_OFS_MODE 4'h5
`define SIO_OFS_DATA_LO 4'h6
`define SIO_OFS_DATA_HI 4'h7

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SIO_IRQ_FLAG_BIT 0
`define SIO_IRQ_MASK_BIT 1
`define SIO_MODE_PIN_FN_BIT 3
`define SIO_PF_TX_BIT 0
`define SIO_PF_RX_BIT 1

// ----------------------------------------------------------------------
// Clock select codes and prescaler taps (tap k gives divide 2^(k+1))
// ----------------------------------------------------------------------
`define SIO_CLK_SYS 3'h6
`define SIO_CLK_EXT 3'h7
`define SIO_TAP_DIV4096 11
`define SIO_TAP_DIV1024 9
`define SIO_TAP_DIV256 7
`define SIO_TAP_DIV64 5
`define SIO_TAP_DIV16 3
`define SIO_TAP_DIV4 1

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define SIO_MODE_RESET 4'h0
`define SIO_PIN_FUNC_RESET 4'h0
`define SIO_MASK_RESET 1'b1
`define SIO_DATA_RESET 8'h00
`define SIO_PRESC_WIDTH 12
`define SIO_MODE_APPLY_CYCLES 2
`define SIO_LAST_COUNT 3'h7

`endif

/* File: hw/sio_pkg.sv */
package sio_pkg;

    typedef enum logic [1:0] {
        SIO_WAIT_START,
        SIO_WAIT_CLOCK,
        SIO_TRANSFER
    } sio_state_t;

endpackage

/* File: hw/sio_sync.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Three-stage pin synchroniser, level accepted when stages two and three agree
// ----------------------------------------------------------------------
module sio_sync (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic pin_in,
    output logic level
);
    import sio_pkg::*;

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            level_q <= 1'b1;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end

    assign level = level_q;

endmodule

/* File: sim/sio_peer.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Far-side serial device: sends tx_q, collects rx_q, can drive the clock
// ----------------------------------------------------------------------
module sio_peer (
    input wire logic sck,
    input wire logic so,
    output logic si,
    output logic sck_drv
);
    logic [7:0] tx_q = 8'h00;
    logic [7:0] rx_q = 8'h00;

    initial si = 1'b1;
    initial sck_drv = 1'b1;

    // Next bit shown at each fall, held until the following fall
    always @(negedge sck) begin
        si = tx_q[0];
        tx_q = {~tx_q[0], tx_q[7:1]};
    end

    always @(posedge sck) begin
        rx_q = {so, rx_q[7:1]};
    end

    // External shift clock, idles high between frames
    task automatic pulses(input int n, input int half);
        repeat (n) begin
            #(half * 8) sck_drv = 1'b0;
            #(half * 8) sck_drv = 1'b1;
        end
    endtask
endmodule

/* File: sim/sio_port_assertions.sv */
`timescale 1ns/1ps

module sio_port_assertions (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_wdata,
    input wire logic [3:0] reg_rdata,
    input wire logic serial_start_instruction,
    input wire logic sck_pin_out,
    input wire logic sck_pin_oe,
    input wire logic so_pin_out,
    input wire logic serial_request,
    input wire logic [3:0] pin_function,
    input sio_pkg::sio_state_t link_state
);
    import sio_pkg::*;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    // ------------------------------------------------------------------
    // Shadow of mode and mask, count of driven clock falls
    // ------------------------------------------------------------------
    logic [3:0] mode_q;
    logic [3:0] cnt_q;
    logic mask_q;
    logic sck_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_q <= 4'h0;
            mask_q <= 1'b1;
        end else if (reg_wr && reg_addr == 4'h5) begin
            mode_q <= reg_wdata;
        end else if (reg_wr && reg_addr == 4'h3) begin
            mask_q <= reg_wdata[1];
        end
    end

    always_ff @(posedge ref_clk) begin
        sck_q <= sck_pin_out;
        if (reset || serial_start_instruction || reg_wr || pin_function[1:0] == 2'h0) begin
            cnt_q <= 4'h0;
        end else if (sck_q && !sck_pin_out && sck_pin_oe && cnt_q != 4'hF) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_mode_wr_wait: assert property (reg_wr && reg_addr == 4'h5 |=> link_state == SIO_WAIT_START)
        else $error("mode write did not enter start-wait");
    a_start_to_wait: assert property (
        serial_start_instruction && !reg_wr && link_state == SIO_WAIT_START |=> link_state == SIO_WAIT_CLOCK)
        else $error("start did not enter clock-wait");
    a_start_aborts: assert property (
        serial_start_instruction && !reg_wr && link_state == SIO_TRANSFER |=> link_state == SIO_WAIT_CLOCK)
        else $error("start in transfer did not return to clock-wait");
    a_frame_end_req: assert property (
        link_state == SIO_TRANSFER ##1 (link_state == SIO_WAIT_CLOCK && !mask_q) |=> serial_request)
        else $error("no request after frame end");
    a_masked_quiet: assert property ($past(mask_q) |-> !serial_request)
        else $error("request seen while masked");
    a_port_fn_off: assert property (!mode_q[3] && !$past(mode_q[3], 3) |-> !sck_pin_oe)
        else $error("clock pin driven in port function");
    a_ext_undriven: assert property (mode_q[2:0] == 3'h7 && $past(mode_q[2:0], 3) == 3'h7 |-> !sck_pin_oe)
        else $error("clock pin driven with external clock");
    a_eight_pulses: assert property (pin_function[1:0] != 2'h0 |-> cnt_q <= 4'h8)
        else $error("more than eight clock pulses");
    a_so_high_hold: assert property (
        sck_pin_oe && sck_pin_out && $past(sck_pin_out) && $past(sck_pin_out, 2) && link_state == SIO_TRANSFER
        |-> $stable(so_pin_out))
        else $error("serial output changed while clock high");
    a_mode_unread: assert property ($past(reg_rd && reg_addr == 4'h5) |-> reg_rdata == 4'h0)
        else $error("mode register readable");
endmodule

bind sio_port sio_port_assertions sio_port_assertions_inst (
    .ref_clk(ref_clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .serial_start_instruction(serial_start_instruction),
    .sck_pin_out(sck_pin_out),
    .sck_pin_oe(sck_pin_oe),
    .so_pin_out(so_pin_out),
    .serial_request(serial_request),
    .pin_function(pin_function),
    .link_state(link_state)
);

/* File: sim/tb.sv */
`timescale 1ns/1ps

module tb;
    import sio_pkg::*;

    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_wdata = 4'h0;
    logic serial_start_instruction = 1'b0;
    logic stop_mode = 1'b0;
    logic [3:0] reg_rdata;
    logic [3:0] pin_function;
    logic sck_pin_out, sck_pin_oe, so_pin_out, so_pin_oe, serial_request, si_w, sck_drv, sck_w, so_w;
    sio_state_t link_state;
    int bad_count = 0;
    int cmp_count = 0;
    int falls = 0;

    always #4 ref_clk = ~ref_clk;
    always @(negedge sck_w) falls++;
    assign sck_w = sck_pin_oe ? sck_pin_out : sck_drv;
    assign so_w = so_pin_oe ? so_pin_out : ~so_pin_out;

    sio_port sio_port_inst (
        .ref_clk(ref_clk),
        .reset(reset),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .serial_start_instruction(serial_start_instruction),
        .stop_mode(stop_mode),
        .sck_pin_in(sck_w),
        .sck_pin_out(sck_pin_out),
        .sck_pin_oe(sck_pin_oe),
        .si_pin_in(si_w),
        .so_pin_out(so_pin_out),
        .so_pin_oe(so_pin_oe),
        .serial_request(serial_request),
        .pin_function(pin_function),
        .link_state(link_state)
    );

    sio_peer sio_peer_inst (
        .sck(sck_w),
        .so(so_w),
        .si(si_w),
        .sck_drv(sck_drv)
    );

    // ------------------------------------------------------------------
    // Expectations
    // ------------------------------------------------------------------
    function automatic int period(input int code);
        return (code == 6) ? 2 : (4096 >> (2 * code));
    endfunction

    function automatic logic [7:0] exp_rx(input logic [7:0] p, input logic [3:0] pf);
        return pf[1] ? p : 8'h00;
    endfunction

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tout();
        bad_count++;
        $display("[FAIL] %0t wait ran out", $time);
        finish_test();
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    endtask

    task automatic rd(input logic [3:0] a, output logic [3:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        d = reg_rdata;
        cyc(1);
    endtask

    task automatic start();
        serial_start_instruction = 1'b1;
        cyc(1);
        serial_start_instruction = 1'b0;
        cyc(1);
    endtask

    task automatic wstate(input sio_state_t s);
        int i;
        for (i = 0; i < 3000 && link_state !== s; i++) cyc(1);
        if (i == 3000) tout();
    endtask

    task automatic wfall(output int n);
        logic p;
        p = sck_pin_out;
        n = 0;
        while (!(p === 1'b1 && sck_pin_out === 1'b0)) begin
            p = sck_pin_out;
            cyc(1);
            n++;
            if (n > 5000) tout();
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [7:0] d, p;
        logic [3:0] lo, hi, pf;
        int n, i;
        d = $urandom(32'hC14F17B1);
        cyc(6);
        reset = 1'b0;
        rd(4'h3, lo);
        chk(lo[1:0], 2'h2);
        for (i = 0; i < 4; i++) begin
            rd((i == 3) ? 4'hA : 4'h5 + i[3:0], lo);
            chk(lo, 4'h0);
        end
        chk(pin_function, 4'h0);
        chk(link_state, SIO_WAIT_START);
        $display("reset test done");
        wr(4'h4, 4'h3);
        wr(4'h5, 4'h4);
        cyc(2);
        start();
        chk(link_state, SIO_WAIT_CLOCK);
        cyc(40);
        chk(sck_pin_oe, 1'b0);
        chk(link_state, SIO_TRANSFER);
        $display("port function test done");
        for (i = 0; i < 4; i++) begin
            pf = (i == 3) ? 4'h1 : 4'h3;
            d = (i == 0) ? 8'hFF : 8'($urandom);
            p = (i == 0) ? 8'h00 : 8'($urandom);
            wr(4'h4, pf);
            wr(4'h5, 4'hC);
            cyc(2);
            wr(4'h6, d[3:0]);
            wr(4'h7, d[7:4]);
            wr(4'h3, 4'h0);
            sio_peer_inst.tx_q = p;
            falls = 0;
            start();
            wstate(SIO_TRANSFER);
            wstate(SIO_WAIT_CLOCK);
            cyc(20);
            chk(falls, 8);
            chk(sio_peer_inst.rx_q, d);
            rd(4'h6, lo);
            rd(4'h7, hi);
            chk({hi, lo}, exp_rx(p, pf));
            chk(serial_request, 1'b1);
            chk(so_pin_oe, pf[0]);
        end
        wr(4'h3, 4'h3);
        cyc(2);
        chk(serial_request, 1'b0);
        rd(4'h3, lo);
        chk(lo[1:0], 2'h3);
        wr(4'h3, 4'h0);
        rd(4'h3, lo);
        chk(lo[1:0], 2'h0);
        $display("transfer test done");
        for (i = 0; i < 7; i++) begin
            wr(4'h5, {1'b1, i[2:0]});
            cyc(2);
            wr(4'h3, 4'h0);
            start();
            wfall(n);
            wfall(n);
            chk(n, period(i));
            wr(4'h5, {1'b1, i[2:0]});
            cyc(3);
            chk(link_state, SIO_WAIT_START);
            chk(serial_request, 1'b1);
        end
        $display("clock select test done");
        wr(4'h4, 4'h2);
        wr(4'h5, 4'hF);
        cyc(2);
        wr(4'h3, 4'h0);
        p = 8'($urandom);
        sio_peer_inst.tx_q = p;
        start();
        sio_peer_inst.pulses(8, 5);
        cyc(10);
        chk(sck_pin_oe, 1'b0);
        chk(so_pin_oe, 1'b0);
        chk(link_state, SIO_WAIT_CLOCK);
        rd(4'h6, lo);
        rd(4'h7, hi);
        chk({hi, lo}, p);
        chk(serial_request, 1'b1);
        start();
        sio_peer_inst.pulses(9, 5);
        cyc(10);
        chk(link_state, SIO_TRANSFER);
        wr(4'h3, 4'h0);
        start();
        chk(link_state, SIO_WAIT_CLOCK);
        cyc(1);
        chk(serial_request, 1'b1);
        $display("external clock test done");
        wr(4'h4, 4'h0);
        wr(4'h5, 4'hD);
        cyc(2);
        start();
        falls = 0;
        cyc(100);
        chk(falls > 8, 1'b1);
        chk(link_state, SIO_WAIT_CLOCK);
        stop_mode = 1'b1;
        cyc(2);
        falls = 0;
        cyc(40);
        chk(falls, 0);
        stop_mode = 1'b0;
        wr(4'h4, 4'h3);
        chk(link_state, SIO_WAIT_START);
        $display("continuous clock test done");
        finish_test();
    end
endmodule
